// File: src/dbgts_pkg.sv
package dbgts_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] REG_TRIGGER_CONFIG = 2'h0;
    localparam logic [1:0] REG_TRACE_STATUS = 2'h1;
    localparam logic [1:0] REG_DEBUG_CONTROL = 2'h2;
    localparam logic [1:0] REG_FIFO_LOW = 2'h3;

    // Trigger configuration fields
    localparam int TC_QUAL_BIT = 7;
    localparam int TC_BEGIN_BIT = 6;
    localparam logic [7:0] TC_WRITE_MASK = 8'hCF;
    localparam logic [7:0] TC_RESET = 8'h00;

    // Debug control fields
    localparam int DC_ENABLE_BIT = 7;
    localparam int DC_ARM_BIT = 6;
    localparam int DC_BREAK_REQUEST_ENABLE_BIT = 4;
    localparam logic [7:0] DC_WRITE_MASK = 8'hD0;
    localparam logic [7:0] DC_RESET = 8'h00;

    // Status fields
    localparam int ST_AF_BIT = 7;
    localparam int ST_BF_BIT = 6;
    localparam int ST_RUN_ACTIVE_FLAG_BIT = 5;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [3:0] FIFO_DEPTH = 4'h8;

    // Trigger mode codes
    localparam logic [3:0] MODE_A_ONLY = 4'h0;
    localparam logic [3:0] MODE_A_OR_B = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B = 4'h2;
    localparam logic [3:0] MODE_EVENT_B = 4'h3;
    localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
    localparam logic [3:0] MODE_A_AND_B = 4'h5;
    localparam logic [3:0] MODE_A_AND_NOT_B = 4'h6;
    localparam logic [3:0] MODE_INSIDE = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE = 4'h8;

    typedef enum logic [1:0] {RUN_IDLE, RUN_WAIT, RUN_STORE} dbgts_run_t;
endpackage

// File: src/dbgts_qualify.sv
`timescale 1ns/1ns
`default_nettype none
// Passes a raw comparator match either directly or only once the opcode
// at that address executes; the tracker reports execution later.
module dbgts_qualify (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tagMode,
    input wire logic rawMatch,
    input wire logic opcodeExec,
    output logic qualMatch
);
    logic pending_r;

    // Remember a tagged match until its opcode runs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_r <= 1'b0;
        end else if (!tagMode || opcodeExec) begin
            pending_r <= 1'b0;
        end else if (rawMatch) begin
            pending_r <= 1'b1;
        end
    end

    assign qualMatch = tagMode ? ((pending_r || rawMatch) && opcodeExec) : rawMatch;
endmodule
`default_nettype wire

// File: src/dbgts_count.sv
`timescale 1ns/1ns
`default_nettype none
// Counts captured FIFO words, saturating at the depth; reads never lower it.
module dbgts_count (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic store,
    output logic [3:0] count_r
);
    import dbgts_pkg::*;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= COUNT_RESET;
        end else if (clear) begin
            count_r <= COUNT_RESET;
        end else if (store && count_r != FIFO_DEPTH) begin
            count_r <= count_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: src/debug_trigger_status.sv
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Contract
// RL1 - Config writable only unarmed; bits 4,5 zero
// RL2 - Bit 7 selects tag or force triggers
// RL3 - Bit 6 selects begin or end trace
// RL4 - Event-only modes always run as begin trace
// RL5 - Modes 0-2: A, A or B, A then B
// RL6 - Modes 3,4: event B, A then event B
// RL7 - Modes 5,6: A and B, A and not B
// RL8 - Modes 7,8: inside or outside range
// RL9 - Codes 1001 to 1111 never trigger
// RL10 - Status register read-only, writes ignored
// RL11 - A flag clears at run start, sets on A
// RL12 - B flag clears at run start, sets on B
// RL13 - Armed flag mirrors arm, clears at run end
// RL14 - Run ends: full in begin, trigger in end
// RL15 - Writing zero to arm or enable stops run
// RL16 - Count clears at start, holds valid words
// RL17 - Count never decrements on FIFO reads
// RL18 - Host tracks words it has read itself
// RL19 - High byte read holds, low byte advances
// RL20 - Break on trigger (end) or full (begin)
// RL21 - Reset clears configuration and status
module debug_trigger_status (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic matchA,
    input wire logic matchB,
    input wire logic addrGeA,
    input wire logic addrLeB,
    input wire logic opcodeExec,
    input wire logic fifoStore,
    input wire logic fifoFull,
    output logic storeEnable,
    output logic fifoAdvance,
    output logic cpuBreak,
    output logic tagBreakType,
    output logic runActive
);
    import dbgts_pkg::*;

    logic [7:0] triggerConfig_r;
    logic [7:0] debugControl_r;
    logic matchAFlag_r;
    logic matchBFlag_r;
    logic seenA_r;
    logic [7:0] regRdData_r;
    logic storeEnable_r;
    logic fifoAdvance_r;
    logic cpuBreak_r;
    logic [3:0] validWordCount;
    dbgts_run_t runState_r;
    dbgts_run_t runState_nxt;

    // Register decode
    wire wrConfig = regWrite && regAddr == REG_TRIGGER_CONFIG;
    wire wrControl = regWrite && regAddr == REG_DEBUG_CONTROL;
    wire rdFifoLow = regRead && regAddr == REG_FIFO_LOW;
    wire moduleEnable = debugControl_r[DC_ENABLE_BIT];
    wire armCtrl = debugControl_r[DC_ARM_BIT];
    wire breakEnable = debugControl_r[DC_BREAK_REQUEST_ENABLE_BIT];
    wire tagQualify = triggerConfig_r[TC_QUAL_BIT];
    wire [3:0] triggerModeSel = triggerConfig_r[3:0];

    // Run starts when arm and enable are written one in the same write while idle
    wire armWriteOne = wrControl && regWrData[DC_ENABLE_BIT] && regWrData[DC_ARM_BIT];
    wire runStart = armWriteOne && runState_r == RUN_IDLE;
    // RL15 manual stop
    wire manualStop = wrControl && (!regWrData[DC_ENABLE_BIT] || !regWrData[DC_ARM_BIT]);

    // RL2 tag or force qualification of each comparator
    wire qualA;
    wire qualB;
    dbgts_qualify uQualA (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tagMode(tagQualify),
        .rawMatch(matchA),
        .opcodeExec(opcodeExec),
        .qualMatch(qualA)
    );
    dbgts_qualify uQualB (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tagMode(tagQualify),
        .rawMatch(matchB),
        .opcodeExec(opcodeExec),
        .qualMatch(qualB)
    );

    // RL4 event-only modes force begin trace
    wire eventOnly = triggerModeSel == MODE_EVENT_B || triggerModeSel == MODE_A_THEN_EVENT_B;
    // RL3 begin or end trace select
    wire beginTrace = triggerConfig_r[TC_BEGIN_BIT] || eventOnly;

    // RL5 RL6 RL7 RL8 RL9 trigger mode decode
    logic trigHit;
    always_comb begin
        unique case (triggerModeSel)
            MODE_A_ONLY: trigHit = qualA;
            MODE_A_OR_B: trigHit = qualA || qualB;
            MODE_A_THEN_B: trigHit = seenA_r && qualB;
            MODE_EVENT_B: trigHit = qualB;
            MODE_A_THEN_EVENT_B: trigHit = seenA_r && qualB;
            MODE_A_AND_B: trigHit = qualA && qualB;
            MODE_A_AND_NOT_B: trigHit = qualA && !matchB;
            MODE_INSIDE: trigHit = addrGeA && addrLeB;
            MODE_OUTSIDE: trigHit = !addrGeA || !addrLeB;
            default: trigHit = 1'b0;
        endcase
    end

    wire running = runState_r != RUN_IDLE;
    // Event-only modes store only on B events; mode 4 also needs a prior A condition
    wire eventStore = triggerModeSel == MODE_EVENT_B ? qualB : seenA_r && qualB;
    // RL14 run end conditions
    wire fullEnd = runState_r == RUN_STORE && fifoFull;
    wire trigEnd = runState_r == RUN_WAIT && !beginTrace && trigHit;
    wire runEnd = running && (fullEnd || trigEnd || manualStop);

    // Run sequencing
    always_comb begin
        runState_nxt = runState_r;
        unique case (runState_r)
            RUN_IDLE: begin
                if (runStart) begin
                    runState_nxt = RUN_WAIT;
                end
            end
            RUN_WAIT: begin
                if (runEnd) begin
                    runState_nxt = RUN_IDLE;
                end else if (beginTrace && (eventOnly || trigHit)) begin
                    runState_nxt = RUN_STORE;
                end
            end
            RUN_STORE: begin
                if (runEnd) begin
                    runState_nxt = RUN_IDLE;
                end
            end
        endcase
    end

    // Storage: circular in end trace, from trigger on in begin trace
    wire storeNow = runState_r == RUN_WAIT ? !beginTrace : runState_r == RUN_STORE;
    wire storeQual = storeNow && (!eventOnly || eventStore);

    // RL16 RL17 valid word count
    dbgts_count uCount (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clear(runStart),
        .store(running && fifoStore),
        .count_r(validWordCount)
    );

    // RL21 run state reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            runState_r <= RUN_IDLE;
        end else begin
            runState_r <= runState_nxt;
        end
    end

    // RL1 config locked while armed; bits 4,5 never stored
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            triggerConfig_r <= TC_RESET;
        end else if (wrConfig && !armCtrl) begin
            triggerConfig_r <= regWrData & TC_WRITE_MASK;
        end
    end

    // RL13 arm clears by itself at run end; arm needs enable
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            debugControl_r <= DC_RESET;
        end else if (wrControl) begin
            debugControl_r <= regWrData & DC_WRITE_MASK
                & {1'b1, regWrData[DC_ENABLE_BIT], 6'h3F};
        end else if (runEnd) begin
            debugControl_r[DC_ARM_BIT] <= 1'b0;
        end
    end

    // RL11 RL12 match flags; a hit in the start cycle is dropped by design
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            matchAFlag_r <= 1'b0;
            matchBFlag_r <= 1'b0;
            seenA_r <= 1'b0;
        end else if (runStart) begin
            matchAFlag_r <= 1'b0;
            matchBFlag_r <= 1'b0;
            seenA_r <= 1'b0;
        end else if (running) begin
            matchAFlag_r <= matchAFlag_r || qualA;
            matchBFlag_r <= matchBFlag_r || qualB;
            seenA_r <= seenA_r || qualA;
        end
    end

    // RL10 status read only; RL19 only low-byte reads advance
    wire [7:0] statusWord = {matchAFlag_r, matchBFlag_r, armCtrl && moduleEnable, 1'b0,
        validWordCount};
    logic [7:0] rdMux;
    always_comb begin
        unique case (regAddr)
            REG_TRIGGER_CONFIG: rdMux = triggerConfig_r;
            REG_TRACE_STATUS: rdMux = statusWord;
            REG_DEBUG_CONTROL: rdMux = debugControl_r;
            default: rdMux = 8'h00;
        endcase
    end

    // Read data valid the cycle after the strobe only
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData_r <= 8'h00;
        end else if (regRead) begin
            regRdData_r <= rdMux;
        end else begin
            regRdData_r <= 8'h00;
        end
    end

    // RL20 break on end-trace trigger or begin-trace full
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cpuBreak_r <= 1'b0;
            storeEnable_r <= 1'b0;
            fifoAdvance_r <= 1'b0;
        end else begin
            cpuBreak_r <= breakEnable && (trigEnd || fullEnd);
            storeEnable_r <= storeQual;
            fifoAdvance_r <= rdFifoLow && !running;
        end
    end

    assign regRdData = regRdData_r;
    assign storeEnable = storeEnable_r;
    assign fifoAdvance = fifoAdvance_r;
    assign cpuBreak = cpuBreak_r;
    assign tagBreakType = 1'b0;
    // Stored arm implies enable, so the arm flop alone drives the pin
    assign runActive = armCtrl;
endmodule
`default_nettype wire

// File: dv/dbgts_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dbgts_sva
    import dbgts_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic fifoAdvance,
    input wire logic cpuBreak,
    input wire logic runActive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Decoded strobes; ctlWr and stRd are shared by several properties, lowRd serves one
    wire logic ctlWr = regWrite && regAddr == REG_DEBUG_CONTROL;
    wire logic stRd = regRead && regAddr == REG_TRACE_STATUS;
    wire logic lowRd = regRead && regAddr == REG_FIFO_LOW;
    a_cfg_zero_bits: assert property (
        regRead && regAddr == REG_TRIGGER_CONFIG |=> regRdData[5:4] == 2'b00)
        else $error("config bits 5:4 not zero");
    a_status_armed: assert property (
        stRd |=> regRdData[5] == $past(runActive))
        else $error("armed bit differs from run state");
    a_arm_sets: assert property (
        ctlWr && regWrData[7:6] == 2'b11 |=> runActive)
        else $error("arm write did not start a run");
    a_stop_run: assert property (
        ctlWr && regWrData[7:6] != 2'b11 |=> !runActive)
        else $error("run kept after stop write");
    a_count_range: assert property (
        stRd |=> regRdData[3:0] <= FIFO_DEPTH)
        else $error("word count above depth");
    a_adv_idle: assert property (
        fifoAdvance == $past(lowRd && !runActive))
        else $error("fifo advance mismatch");
    a_break_end: assert property (
        cpuBreak |-> !runActive && $past(runActive))
        else $error("break without run end");
    a_break_pulse: assert property (
        cpuBreak |=> !cpuBreak)
        else $error("break longer than one cycle");
    c_arm: cover property (ctlWr && regWrData[7:6] == 2'b11);
    c_break: cover property (cpuBreak);
    c_advance: cover property (fifoAdvance);
endmodule
bind debug_trigger_status dbgts_sva chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .fifoAdvance(fifoAdvance), .cpuBreak(cpuBreak),
    .runActive(runActive));
`default_nettype wire

// File: dv/dbgts_host.sv
`timescale 1ns/1ns
`default_nettype none
// Debug host: owns the register port and tallies its own FIFO reads
module dbgts_host
    import dbgts_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [7:0] regRdData,
    output logic [1:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrite,
    output logic regRead
);
    int fifoReads = 0;
    initial begin
        {regAddr, regWrData, regWrite, regRead} = 12'h000;
    end
    // Data turns over after the strobe so stale bytes never look valid
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 d = regRdData;
        if (a == REG_FIFO_LOW) fifoReads++;
    endtask
endmodule
`default_nettype wire

// File: dv/debug_trigger_status_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module debug_trigger_status_tb_top;
    import dbgts_pkg::*;
    logic ref_clk, reset_n, matchA, matchB, addrGeA, addrLeB, opcodeExec, fifoStore, fifoFull;
    logic [1:0] regAddr;
    logic [7:0] regWrData, regRdData, rdv;
    logic regWrite, regRead, storeEnable, fifoAdvance, cpuBreak, tagBreakType, runActive;
    int errorCnt = 0;
    int checked = 0;
    int cycles = 0;
    // {mode, first hit, second hit, ends} with hits as {A, B, geA, leB}
    logic [15:0] cases [15] = '{16'h0801, 16'h0400, 16'h1401, 16'h2480, 16'h2841,
        16'h5C01, 16'h5800, 16'h6801, 16'h6C00, 16'h7110, 16'h7331, 16'h8330,
        16'h8321, 16'h9FF0, 16'hFFF0};
    dbgts_host host (.ref_clk(ref_clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));
    debug_trigger_status uut (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .matchA(matchA), .matchB(matchB), .addrGeA(addrGeA),
        .addrLeB(addrLeB), .opcodeExec(opcodeExec), .fifoStore(fifoStore),
        .fifoFull(fifoFull), .storeEnable(storeEnable), .fifoAdvance(fifoAdvance),
        .cpuBreak(cpuBreak), .tagBreakType(tagBreakType), .runActive(runActive));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finalReport();
        if (errorCnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Waits land 1 ns past the edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic hit(input logic [3:0] v);
        @(posedge ref_clk);
        {matchA, matchB, addrGeA, addrLeB} <= v;
        @(posedge ref_clk);
        {matchA, matchB} <= 2'b00;
    endtask
    task automatic regTest();
        for (int a = 0; a < 3; a++) begin
            host.rd(a[1:0], rdv);
            chk(rdv, 8'h00);
        end
        host.wr(REG_TRIGGER_CONFIG, 8'hFF);
        host.rd(REG_TRIGGER_CONFIG, rdv);
        chk(rdv, 8'hCF);
        host.wr(REG_TRACE_STATUS, 8'hFF);
        host.rd(REG_TRACE_STATUS, rdv);
        chk(rdv, 8'h00);
        host.wr(REG_DEBUG_CONTROL, 8'h40);
        cyc(1);
        chk({7'h00, runActive}, 8'h00);
        chk({7'h00, tagBreakType}, 8'h00);
        host.wr(REG_TRIGGER_CONFIG, 8'h00);
    endtask
    task automatic endTrace();
        logic brk;
        brk = 1'b0;
        host.wr(REG_DEBUG_CONTROL, 8'hD0);
        host.wr(REG_TRIGGER_CONFIG, 8'h41);
        host.rd(REG_TRIGGER_CONFIG, rdv);
        chk(rdv, 8'h00);
        chk({7'h00, storeEnable}, 8'h01);
        repeat (3) begin
            @(posedge ref_clk);
            fifoStore <= 1'b1;
            @(posedge ref_clk);
            fifoStore <= 1'b0;
        end
        host.rd(REG_TRACE_STATUS, rdv);
        chk(rdv, 8'h23);
        hit(4'h8);
        repeat (4) begin
            #1 brk = brk | cpuBreak;
            @(posedge ref_clk);
        end
        chk({7'h00, brk}, 8'h01);
        host.rd(REG_TRACE_STATUS, rdv);
        chk(rdv, 8'h83);
        host.wr(REG_DEBUG_CONTROL, 8'h00);
    endtask
    task automatic eventRun();
        host.wr(REG_TRIGGER_CONFIG, 8'h03);
        host.wr(REG_DEBUG_CONTROL, 8'hC0);
        repeat (10) begin
            @(posedge ref_clk);
            {matchB, fifoStore} <= 2'b11;
            @(posedge ref_clk);
            {matchB, fifoStore} <= 2'b00;
        end
        cyc(1);
        chk({7'h00, runActive}, 8'h01);
        fifoFull <= 1'b1;
        cyc(3);
        fifoFull <= 1'b0;
        chk({7'h00, runActive}, 8'h00);
        host.rd(REG_TRACE_STATUS, rdv);
        chk(rdv, 8'h48);
        repeat (3) host.rd(REG_FIFO_LOW, rdv);
        host.rd(REG_TRACE_STATUS, rdv);
        chk(rdv, 8'h48);
    endtask
    task automatic qualRun();
        host.wr(REG_TRIGGER_CONFIG, 8'hC0);
        host.wr(REG_DEBUG_CONTROL, 8'hC0);
        hit(4'h8);
        cyc(3);
        chk({6'h00, runActive, storeEnable}, 8'h02);
        opcodeExec <= 1'b1;
        cyc(1);
        opcodeExec <= 1'b0;
        cyc(3);
        chk({6'h00, runActive, storeEnable}, 8'h03);
        host.wr(REG_DEBUG_CONTROL, 8'h80);
        cyc(1);
        chk({7'h00, runActive}, 8'h00);
    endtask
    task automatic modeCase(input logic [15:0] c);
        hit({2'b00, c[9:8]});
        host.wr(REG_TRIGGER_CONFIG, {4'h0, c[15:12]});
        host.wr(REG_DEBUG_CONTROL, 8'hC0);
        hit(c[11:8]);
        hit(c[7:4]);
        cyc(3);
        chk({7'h00, runActive}, {7'h00, ~c[0]});
        host.wr(REG_DEBUG_CONTROL, 8'h00);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errorCnt++;
            finalReport();
        end
    end
    initial begin
        {reset_n, matchA, matchB, addrGeA, addrLeB, opcodeExec, fifoStore, fifoFull} = 8'h00;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        regTest();
        endTrace();
        eventRun();
        qualRun();
        foreach (cases[i]) modeCase(cases[i]);
        finalReport();
    end
endmodule
`default_nettype wire
